// >>> core/pac_core.sv
// Pulse accumulator control, flags, count and timer clock select behind a Wishbone slave.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
module pac_core (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic CHANNEL_SEVEN_PIN,
  input wire logic PRESCALER_TICK,
  input wire logic GATE_DIV64_TICK,
  output logic MAIN_COUNTER_TICK,
  output logic OVERFLOW_IRQ,
  output logic INPUT_EDGE_IRQ
);
  import pac_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [1:0] flag_q;
  logic [1:0] flag_d;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [7:0] timer_q;
  logic [7:0] timer_d;
  logic [7:0] div256_q;
  logic [15:0] div64k_q;
  logic [31:0] dat_q;
  logic ack_q;
  logic tick_q;
  logic ovf_irq_q;
  logic inp_irq_q;
  logic pin_q;

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  logic pin_level;
  logic pin_rise;
  logic pin_fall;

  pac_sync u_sync (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .async_in(CHANNEL_SEVEN_PIN),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] nw, input logic en);
    merge_byte = en ? nw : old;
  endfunction : merge_byte

  wire logic req = WB_CYC_I & WB_STB_I & ~ack_q;
  wire logic wr = req & WB_WE_I;
  wire logic hit_ctrl = WB_ADR_I == PAC_OFF_CTRL;
  wire logic hit_flags = WB_ADR_I == PAC_OFF_FLAGS;
  wire logic hit_count = WB_ADR_I == PAC_OFF_COUNT;
  wire logic hit_timer = WB_ADR_I == PAC_OFF_TIMER;
  wire logic hit_status = WB_ADR_I == PAC_OFF_STATUS;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire logic accum_enable = ctrl_q[PAC_B_ENABLE];
  wire logic accum_mode_select = ctrl_q[PAC_B_MODE];
  wire logic accum_edge_polarity = ctrl_q[PAC_B_EDGE];
  wire logic timer_global_enable = timer_q[PAC_B_TEN];
  wire logic fast_flag_clear_enable = timer_q[PAC_B_FFCA];
  wire pac_clksel_e clk_sel = pac_clksel_e'(ctrl_q[PAC_B_CLKSEL_HI:PAC_B_CLKSEL_LO]);

  // Event mode edge per polarity, independent of timer enable.
  wire logic event_edge = accum_edge_polarity ? pin_rise : pin_fall;
  // Gate is active on high level for polarity 0, low level for 1.
  wire logic gate_active = pin_level ^ accum_edge_polarity;
  wire logic gate_trailing = accum_edge_polarity ? pin_rise : pin_fall;
  // The divided clock exists only while the timer runs.
  wire logic gate_pulse = GATE_DIV64_TICK & timer_global_enable & gate_active;
  wire logic event_mode = accum_enable & ~accum_mode_select;
  wire logic gated_mode = accum_enable & accum_mode_select;
  wire logic count_inc = (event_mode & event_edge) | (gated_mode & gate_pulse);
  wire logic inp_set = (event_mode & event_edge) | (gated_mode & gate_trailing);
  wire logic wrap = count_inc & (count_q == PAC_COUNT_MAX);
  // Derived clock ticks on every accumulator increment.
  wire logic accum_derived_clock = count_inc;
  wire logic div256_tick = accum_derived_clock & (div256_q == PAC_DIV256_LAST);
  wire logic div64k_tick = accum_derived_clock & (div64k_q == PAC_DIV64K_LAST);
  wire logic fast_clear = req & hit_count & fast_flag_clear_enable;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  always_comb
  begin
    ctrl_d = ctrl_q;
    timer_d = timer_q;
    count_d = count_q;
    flag_d = flag_q;
    if (wr && hit_ctrl)
    begin
      ctrl_d = merge_byte(ctrl_q, WB_DAT_I[7:0] & PAC_CTRL_MASK, WB_SEL_I[0]);
    end
    if (wr && hit_timer)
    begin
      timer_d = merge_byte(timer_q, WB_DAT_I[7:0] & PAC_TIMER_MASK, WB_SEL_I[0]);
    end
    if (count_inc)
    begin
      count_d = count_q + 16'h0001;
    end
    if (wr && hit_count)
    begin
      count_d = {merge_byte(count_q[15:8], WB_DAT_I[15:8], WB_SEL_I[1]),
                 merge_byte(count_q[7:0], WB_DAT_I[7:0], WB_SEL_I[0])};
    end
    if (wr && hit_flags && WB_SEL_I[0])
    begin
      flag_d = flag_q & ~WB_DAT_I[1:0];
    end
    if (fast_clear)
    begin
      flag_d = 2'b00;
    end
    // Hardware set wins over any clear in the same cycle.
    if (wrap)
    begin
      flag_d[PAC_B_OVF_FLAG] = 1'b1;
    end
    if (inp_set)
    begin
      flag_d[PAC_B_INP_FLAG] = 1'b1;
    end
  end

  // Read mux; unused bits read zero.
  wire logic [31:0] rd_data =
    hit_ctrl ? {24'h000000, ctrl_q & PAC_CTRL_MASK} :
    hit_flags ? {30'h00000000, flag_q} :
    hit_count ? {16'h0000, count_q} :
    hit_timer ? {24'h000000, timer_q} :
    hit_status ? {30'h00000000, gate_active, pin_level} :
    32'h00000000;

  // Clock select applies the cycle after the write.
  wire logic tick_d =
    !accum_enable ? PRESCALER_TICK :
    (clk_sel == PAC_CLK_PRESCALER) ? PRESCALER_TICK :
    (clk_sel == PAC_CLK_ACCUM) ? accum_derived_clock :
    (clk_sel == PAC_CLK_ACCUM_256) ? div256_tick :
    div64k_tick;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      ctrl_q <= PAC_CTRL_RESET;
      timer_q <= 8'h00;
      count_q <= PAC_COUNT_RESET;
      flag_q <= 2'b00;
      div256_q <= 8'h00;
      div64k_q <= 16'h0000;
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      tick_q <= 1'b0;
      ovf_irq_q <= 1'b0;
      inp_irq_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      timer_q <= timer_d;
      count_q <= count_d;
      flag_q <= flag_d;
      if (accum_derived_clock)
      begin
        div256_q <= div256_q + 8'h01;
        div64k_q <= div64k_q + 16'h0001;
      end
      ack_q <= req;
      dat_q <= req ? rd_data : 32'h00000000;
      tick_q <= tick_d;
      ovf_irq_q <= flag_q[PAC_B_OVF_FLAG] & ctrl_q[PAC_B_OVF_IE];
      inp_irq_q <= flag_q[PAC_B_INP_FLAG] & ctrl_q[PAC_B_INP_IE];
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;
  assign MAIN_COUNTER_TICK = tick_q;
  assign OVERFLOW_IRQ = ovf_irq_q;
  assign INPUT_EDGE_IRQ = inp_irq_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      pin_q <= 1'b0;
    end
    else
    begin
      pin_q <= pin_level;
    end
  end

  a_count_disabled: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !accum_enable && !(wr && hit_count) |=> count_q == $past(count_q))
    else $error("Count moved while accumulator disabled.");

  a_event_count: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    event_mode && event_edge && !(wr && hit_count) |=> count_q == $past(count_q) + 16'h0001)
    else $error("Event edge did not increment count.");

  a_gate_needs_ten: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    gated_mode && !timer_global_enable && !(wr && hit_count) |=> count_q == $past(count_q))
    else $error("Gated count advanced with timer disabled.");

  a_event_no_ten: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    event_mode && !timer_global_enable && pin_fall && !accum_edge_polarity && !(wr && hit_count)
    |=> count_q != $past(count_q))
    else $error("Event mode stalled without timer enable.");

  a_gated_trail: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    gated_mode && !accum_edge_polarity && pin_q && !pin_level |=> flag_q[PAC_B_INP_FLAG])
    else $error("Trailing gate edge did not set input flag.");

  a_wrap_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    wrap && !(wr && hit_count) |=> flag_q[PAC_B_OVF_FLAG] && count_q == PAC_COUNT_RESET)
    else $error("Wrap did not set overflow flag.");

  a_w1c_inp: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    wr && hit_flags && WB_SEL_I[0] && WB_DAT_I[0] && !inp_set |=> !flag_q[PAC_B_INP_FLAG])
    else $error("Write one did not clear input flag.");

  a_fast_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    fast_clear && !wrap && !inp_set |=> flag_q == 2'b00)
    else $error("Fast clear left a flag set.");

  a_irq_ovf: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ##1 OVERFLOW_IRQ == ($past(flag_q[PAC_B_OVF_FLAG]) && $past(ctrl_q[PAC_B_OVF_IE])))
    else $error("Overflow interrupt does not follow flag and enable.");

  a_irq_inp: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ##1 INPUT_EDGE_IRQ == ($past(flag_q[PAC_B_INP_FLAG]) && $past(ctrl_q[PAC_B_INP_IE])))
    else $error("Input interrupt does not follow flag and enable.");

  a_clk_disabled: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !accum_enable |=> MAIN_COUNTER_TICK == $past(PRESCALER_TICK))
    else $error("Disabled accumulator did not use prescaler clock.");

  a_ctrl_rsvd: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    req && !WB_WE_I && hit_ctrl |=> WB_DAT_O[31:7] == 25'h0000000)
    else $error("Reserved control bit read as one.");

  a_flags_rsvd: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    req && !WB_WE_I && hit_flags |=> WB_DAT_O[31:2] == 30'h00000000)
    else $error("Reserved flag bit read as one.");

  // Every taken request is answered on the next edge, and idle read data is zero.
  a_ack_follows: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    req |=> WB_ACK_O)
    else $error("Request was not acknowledged.");

  a_idle_data_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !WB_ACK_O |-> WB_DAT_O == 32'h00000000)
    else $error("Read data not zero outside acknowledge.");

  a_ctrl_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    wr && hit_ctrl && WB_SEL_I[0] |=> ctrl_q == ($past(WB_DAT_I[7:0]) & PAC_CTRL_MASK))
    else $error("Control write did not land.");

  a_count_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    wr && hit_count && WB_SEL_I[1:0] == 2'b11 |=> count_q == $past(WB_DAT_I[15:0]))
    else $error("Count write did not land.");

  a_event_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    event_mode && event_edge |=> flag_q[PAC_B_INP_FLAG])
    else $error("Event edge did not set input flag.");

  a_w1c_ovf: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    wr && hit_flags && WB_SEL_I[0] && WB_DAT_I[1] && !wrap |=> !flag_q[PAC_B_OVF_FLAG])
    else $error("Write one did not clear overflow flag.");

  a_write_zero_keeps: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    wr && hit_flags && WB_SEL_I[0] && !WB_DAT_I[0] && flag_q[PAC_B_INP_FLAG] |=> flag_q[PAC_B_INP_FLAG])
    else $error("Write zero cleared input flag.");

  a_gate_count: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    gated_mode && GATE_DIV64_TICK && timer_global_enable && gate_active && !(wr && hit_count)
    |=> count_q == $past(count_q) + 16'h0001)
    else $error("Gated tick did not increment count.");

  a_gate_idle: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    gated_mode && !gate_active && !(wr && hit_count) |=> count_q == $past(count_q))
    else $error("Count moved with gate inactive.");

  // The main counter clock follows the selection made by the control bits.
  a_clk_presc: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    accum_enable && clk_sel == PAC_CLK_PRESCALER |=> MAIN_COUNTER_TICK == $past(PRESCALER_TICK))
    else $error("Prescaler selection not followed.");

  a_clk_accum: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    accum_enable && clk_sel == PAC_CLK_ACCUM |=> MAIN_COUNTER_TICK == $past(count_inc))
    else $error("Accumulator clock selection not followed.");

  a_clk_div256: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    accum_enable && clk_sel == PAC_CLK_ACCUM_256 && !(count_inc && div256_q == PAC_DIV256_LAST) |=> !MAIN_COUNTER_TICK)
    else $error("Divide by 256 ticked early.");

  a_clk_div64k: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    accum_enable && clk_sel == PAC_CLK_ACCUM_64K && div64k_q != PAC_DIV64K_LAST |=> !MAIN_COUNTER_TICK)
    else $error("Divide by 65536 ticked early.");

endmodule : pac_core

// >>> pkg/pac_pkg.sv
// Package with register map, field positions and constants of the pulse accumulator.
package pac_pkg;

  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] PAC_OFF_CTRL = 8'h20;
  localparam logic [7:0] PAC_OFF_FLAGS = 8'h21;
  localparam logic [7:0] PAC_OFF_COUNT = 8'h22;
  localparam logic [7:0] PAC_OFF_TIMER = 8'h24;
  localparam logic [7:0] PAC_OFF_STATUS = 8'h28;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PAC_B_ENABLE = 6;
  localparam int PAC_B_MODE = 5;
  localparam int PAC_B_EDGE = 4;
  localparam int PAC_B_CLKSEL_HI = 3;
  localparam int PAC_B_CLKSEL_LO = 2;
  localparam int PAC_B_OVF_IE = 1;
  localparam int PAC_B_INP_IE = 0;
  localparam int PAC_B_OVF_FLAG = 1;
  localparam int PAC_B_INP_FLAG = 0;
  localparam int PAC_B_TEN = 7;
  localparam int PAC_B_FFCA = 4;

  // ----------------------------------------
  // Masks and reset values
  // ----------------------------------------
  localparam logic [7:0] PAC_CTRL_MASK = 8'h7F;
  localparam logic [7:0] PAC_FLAG_MASK = 8'h03;
  localparam logic [7:0] PAC_TIMER_MASK = 8'h90;
  localparam logic [7:0] PAC_CTRL_RESET = 8'h00;
  localparam logic [15:0] PAC_COUNT_RESET = 16'h0000;
  localparam logic [15:0] PAC_COUNT_MAX = 16'hFFFF;

  // ----------------------------------------
  // Timing and clock selection
  // ----------------------------------------
  localparam int PAC_GATE_DIV = 64;
  localparam logic [5:0] PAC_GATE_LAST = 6'(PAC_GATE_DIV - 1);
  localparam logic [7:0] PAC_DIV256_LAST = 8'hFF;
  localparam logic [15:0] PAC_DIV64K_LAST = 16'hFFFF;

  typedef enum logic [1:0] {
    PAC_CLK_PRESCALER,
    PAC_CLK_ACCUM,
    PAC_CLK_ACCUM_256,
    PAC_CLK_ACCUM_64K
  } pac_clksel_e;

endpackage : pac_pkg

// >>> core/pac_sync.sv
// Two-stage synchroniser with edge detection behind the second stage.
`timescale 1ns/10ps
module pac_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule : pac_sync

// >>> sim/pac_pin_model.sv
// Model of the external pulse or gate source on the shared channel-seven pin.
`timescale 1ns/10ps
module pac_pin_model (
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b0;

  // A level change is launched after a clock edge and held for at least three bus clocks.
  task automatic drive(input logic level, input int hold);
    @(posedge clk);
    pin <= level;
    repeat ((hold < 3) ? 3 : hold) @(posedge clk);
  endtask : drive
endmodule : pac_pin_model

// >>> sim/pulse_accumulator_control_tb.sv
// Self-checking testbench of the pulse accumulator control block.
`timescale 1ns/10ps
module pulse_accumulator_control_tb;
  import pac_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic pre_tick = 1'b0;
  logic gate_tick = 1'b0;
  logic [31:0] rdat;
  logic ack;
  logic pin;
  logic main_tick;
  logic ovf_irq;
  logic inp_irq;
  int failures = 0;
  int total_checks = 0;
  int main_ticks = 0;

  always #2.5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) main_ticks += (main_tick === 1'b1) ? 1 : 0;

  pac_core u_pac_core (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CHANNEL_SEVEN_PIN(pin),
    .PRESCALER_TICK(pre_tick), .GATE_DIV64_TICK(gate_tick), .MAIN_COUNTER_TICK(main_tick),
    .OVERFLOW_IRQ(ovf_irq), .INPUT_EDGE_IRQ(inp_irq)
  );

  pac_pin_model u_pac_pin_model (
    .clk(clk_sys),
    .pin(pin)
  );

  // ----------------------------------------
  // Bus, compare and stimulus tasks
  // ----------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_reg

  task automatic check_irq(input logic [1:0] exp);
    @(negedge clk_sys);
    total_checks++;
    if ({ovf_irq, inp_irq} !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, {ovf_irq, inp_irq}, exp);
    end
  endtask : check_irq

  // The request stands until ack is sampled high at a rising edge; data is taken and the request released there.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    q = 32'h00000000;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= (a == PAC_OFF_COUNT) ? 4'h3 : 4'h1;
    wdat <= d;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack === 1'b1)
    begin
      q = rdat;
    end
    else
    begin
      failures++;
      results();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check_reg(q, exp);
  endtask : rd

  task automatic ticks(input logic [1:0] which, input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      {gate_tick, pre_tick} <= which;
      @(posedge clk_sys);
      {gate_tick, pre_tick} <= 2'b00;
    end
    repeat (3) @(posedge clk_sys);
  endtask : ticks

  task automatic pulse(input int n);
    repeat (n)
    begin
      u_pac_pin_model.drive(1'b1, 4);
      u_pac_pin_model.drive(1'b0, 4);
    end
  endtask : pulse

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_regs();
    rd(PAC_OFF_CTRL, 32'h0);
    rd(PAC_OFF_FLAGS, 32'h0);
    rd(PAC_OFF_COUNT, 32'h0);
    wr(PAC_OFF_CTRL, 32'hFF);
    rd(PAC_OFF_CTRL, 32'h7F);
    wr(PAC_OFF_FLAGS, 32'hFC);
    rd(PAC_OFF_FLAGS, 32'h0);
    rd(8'h30, 32'h0);
    wr(PAC_OFF_CTRL, 32'h0);
  endtask : s_regs

  task automatic s_event();
    wr(PAC_OFF_CTRL, 32'h40);
    u_pac_pin_model.drive(1'b1, 4);
    rd(PAC_OFF_COUNT, 32'h0);
    u_pac_pin_model.drive(1'b0, 4);
    rd(PAC_OFF_COUNT, 32'h1);
    wr(PAC_OFF_FLAGS, 32'h0);
    rd(PAC_OFF_FLAGS, 32'h1);
    wr(PAC_OFF_FLAGS, 32'h1);
    rd(PAC_OFF_FLAGS, 32'h0);
    wr(PAC_OFF_CTRL, 32'h50);
    pulse(2);
    rd(PAC_OFF_COUNT, 32'h3);
    wr(PAC_OFF_CTRL, 32'h10);
    pulse(2);
    rd(PAC_OFF_COUNT, 32'h3);
  endtask : s_event

  task automatic s_irq();
    wr(PAC_OFF_FLAGS, 32'h3);
    wr(PAC_OFF_COUNT, 32'hFFFF);
    wr(PAC_OFF_CTRL, 32'h43);
    check_irq(2'b00);
    pulse(1);
    rd(PAC_OFF_COUNT, 32'h0);
    rd(PAC_OFF_FLAGS, 32'h3);
    check_irq(2'b11);
    wr(PAC_OFF_CTRL, 32'h40);
    check_irq(2'b00);
    wr(PAC_OFF_FLAGS, 32'h2);
    rd(PAC_OFF_FLAGS, 32'h1);
    wr(PAC_OFF_TIMER, 32'h10);
    rd(PAC_OFF_TIMER, 32'h10);
    rd(PAC_OFF_COUNT, 32'h0);
    rd(PAC_OFF_FLAGS, 32'h0);
    pulse(1);
    wr(PAC_OFF_COUNT, 32'h0);
    rd(PAC_OFF_FLAGS, 32'h0);
    wr(PAC_OFF_TIMER, 32'h0);
  endtask : s_irq

  task automatic s_gated();
    wr(PAC_OFF_TIMER, 32'h80);
    wr(PAC_OFF_CTRL, 32'h60);
    u_pac_pin_model.drive(1'b1, 4);
    rd(PAC_OFF_STATUS, 32'h3);
    ticks(2'b10, 3);
    u_pac_pin_model.drive(1'b0, 4);
    rd(PAC_OFF_COUNT, 32'h3);
    rd(PAC_OFF_FLAGS, 32'h1);
    ticks(2'b10, 2);
    rd(PAC_OFF_COUNT, 32'h3);
    wr(PAC_OFF_TIMER, 32'h0);
    wr(PAC_OFF_CTRL, 32'h70);
    ticks(2'b10, 2);
    rd(PAC_OFF_COUNT, 32'h3);
    wr(PAC_OFF_TIMER, 32'h80);
    wr(PAC_OFF_FLAGS, 32'h1);
    ticks(2'b10, 2);
    u_pac_pin_model.drive(1'b1, 4);
    rd(PAC_OFF_COUNT, 32'h5);
    rd(PAC_OFF_FLAGS, 32'h1);
  endtask : s_gated

  task automatic s_clksel();
    wr(PAC_OFF_CTRL, 32'h0C);
    main_ticks = 0;
    ticks(2'b01, 4);
    check_reg(32'(main_ticks), 32'h4);
    wr(PAC_OFF_CTRL, 32'h44);
    main_ticks = 0;
    ticks(2'b01, 4);
    u_pac_pin_model.drive(1'b0, 4);
    repeat (3) @(posedge clk_sys);
    check_reg(32'(main_ticks), 32'h1);
    wr(PAC_OFF_CTRL, 32'h48);
    main_ticks = 0;
    pulse(256);
    repeat (3) @(posedge clk_sys);
    check_reg(32'(main_ticks), 32'h1);
    wr(PAC_OFF_CTRL, 32'h4C);
    main_ticks = 0;
    ticks(2'b01, 2);
    pulse(2);
    repeat (3) @(posedge clk_sys);
    check_reg(32'(main_ticks), 32'h0);
    wr(PAC_OFF_CTRL, 32'h40);
    main_ticks = 0;
    ticks(2'b01, 3);
    check_reg(32'(main_ticks), 32'h3);
  endtask : s_clksel

  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    s_regs();
    s_event();
    s_irq();
    s_gated();
    s_clksel();
    results();
  end
endmodule : pulse_accumulator_control_tb
